/* rtl/ris_top.sv */
// ris_top: reset sequencing, prescaler and interrupt arbitration
`timescale 1ns/10ps

// Functional notes
// - low voltage: flag, pin 4128 ticks, hold 32
// - internal resets drive reset pin low actively
// - SE0 longer than 2.5 us is bus reset
// - address acceptance ready within 10 ms
// - bus reset may be blocked or raise irq
// - USB disabled: bus reset ignored
// - 13-bit prescaler on reference falling edges
// - prescaler overflow ticks the watchdog
// - stop clears prescaler; recovery 32 or 4096
// - external reset pin leaves prescaler alone
// - prescaler free-runs after every reset
// - entry: stack registers, set mask bit
// - latch, arbitrate, give fixed vector code
// - latched interrupt holds until serviced
// - only at boundaries, unmasked and enabled
// - highest priority pending served first
// - pending at return served before next
// - high index register not stacked
// - software interrupt ignores mask, pushes PC
// - flags 1..15 map FFFA down to FFDE
// - flags show live requests; low bits zero
// - reset above all, vector FFFE
module ris_top
  import ris_pkg::*;
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic osc_reference_clock, // oscillator reference pin
  input wire logic low_voltage_detect, // supply trip from detector
  input wire logic usb_dp, // usb data plus pin
  input wire logic usb_dm, // usb data minus pin
  input wire logic rst_pin_i, // reset pin level
  output logic rst_pin_o, // reset pin drive value
  output logic rst_pin_oe, // reset pin drive enable
  output logic cpu_reset_n, // cpu held in reset, active low
  output logic cpu_clk_en, // cpu and peripheral clocks run
  output logic watchdog_tick, // one pulse per prescaler wrap
  output logic usb_addr_ready, // address may be accepted
  output logic usb_ext_irq, // bus reset as external request
  input wire logic stop_instr, // cpu executes stop, pulse
  input wire logic break_in, // break request level
  input wire logic [15:1] irq_req, // peripheral request lines
  input wire logic [15:1] irq_en, // peripheral source enables
  input wire logic cpu_ibit, // cpu interrupt mask bit
  input wire logic instr_boundary, // cpu at instruction end
  input wire logic swi_instr, // software interrupt decoded
  input wire logic vec_ack, // cpu fetched the vector, pulse
  output logic vec_valid, // a vector choice is latched
  output logic [4:0] vec_code, // arbitration code
  output logic [15:0] vec_addr, // vector address to fetch
  output logic stack_push, // start stacking, pulse
  output logic push_pc_minus_one, // hardware entry pushes pc-1
  output logic push_hreg, // stack high index register
  output logic set_ibit // set cpu mask bit, pulse
);

  // ===========================================================
  // input synchronisers
  logic [1:0] osc_sync_r;
  logic [1:0] lvd_sync_r;
  logic [1:0] dp_sync_r;
  logic [1:0] dm_sync_r;
  logic [1:0] pin_sync_r;
  logic osc_prev_r;
  logic lvd_prev_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_sync_r <= 2'h0;
      lvd_sync_r <= 2'h0;
      dp_sync_r <= 2'h0;
      dm_sync_r <= 2'h0;
      pin_sync_r <= 2'h3;
      osc_prev_r <= 1'b0;
      lvd_prev_r <= 1'b0;
    end else begin
      osc_sync_r <= {osc_sync_r[0], osc_reference_clock};
      lvd_sync_r <= {lvd_sync_r[0], low_voltage_detect};
      dp_sync_r <= {dp_sync_r[0], usb_dp};
      dm_sync_r <= {dm_sync_r[0], usb_dm};
      pin_sync_r <= {pin_sync_r[0], rst_pin_i};
      osc_prev_r <= osc_sync_r[1];
      lvd_prev_r <= lvd_sync_r[1];
    end
  end

  // reference clock must be well below pclk/2 for edge capture
  logic ref_tick;
  logic lv_trip;
  logic se0;
  assign ref_tick = osc_prev_r & ~osc_sync_r[1];
  assign lv_trip = lvd_sync_r[1] & ~lvd_prev_r;
  assign se0 = ~dp_sync_r[1] & ~dm_sync_r[1];

  // ===========================================================
  // control register
  logic [3:0] ctrl_r;
  logic apb_wr;
  logic apb_setup;
  assign apb_wr = psel & penable & pready & pwrite;
  assign apb_setup = psel & ~penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RESET;
    end else if (apb_wr && paddr == OFS_CTRL) begin
      ctrl_r <= pwdata[3:0];
    end
  end

  // ===========================================================
  // usb bus reset detection
  logic [SE0_CNT_W-1:0] se0_cnt_r;
  logic se0_long_r;
  logic usb_bus_rst;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      se0_cnt_r <= '0;
    end else if (!se0 || !ctrl_r[CTRL_USB_EN]) begin
      se0_cnt_r <= '0;
    end else if (se0_cnt_r <= SE0_CNT_W'(SE0_MIN_CYC)) begin
      se0_cnt_r <= se0_cnt_r + 1'b1;
    end
  end

  // counter passes SE0_MIN_CYC only when SE0 lasted longer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      se0_long_r <= 1'b0;
    end else begin
      se0_long_r <= se0_cnt_r > SE0_CNT_W'(SE0_MIN_CYC);
    end
  end

  // disabled module swallows the event
  assign usb_bus_rst = se0_cnt_r == SE0_CNT_W'(SE0_MIN_CYC + 1) &&
                       !se0_long_r && ctrl_r[CTRL_USB_EN];

  logic usb_int_rst;
  assign usb_int_rst = usb_bus_rst & ~ctrl_r[CTRL_USB_RST_DIS];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_ext_irq <= 1'b0;
    end else begin
      usb_ext_irq <= usb_bus_rst & ctrl_r[CTRL_USB_TO_IRQ];
    end
  end

  // ready one cycle after SE0 ends, well inside 10 ms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_addr_ready <= 1'b1;
    end else if (se0_long_r) begin
      usb_addr_ready <= ~se0;
    end else if (!ctrl_r[CTRL_USB_EN]) begin
      usb_addr_ready <= 1'b0;
    end else begin
      usb_addr_ready <= 1'b1;
    end
  end

  // ===========================================================
  // reset and stop sequencer
  ris_state_t state_r;
  logic [12:0] presc_r;
  logic [12:0] pin_len_r;
  logic [12:0] rec_len;
  logic lv_cause_r;
  logic usb_cause_r;
  logic int_rst;
  logic wake;

  assign int_rst = lv_trip | usb_int_rst;
  assign rec_len = ctrl_r[CTRL_SHORT_REC] ? REC_SHORT_TICKS
                                           : REC_LONG_TICKS;
  assign wake = |(irq_req & irq_en) | break_in | ~pin_sync_r[1] |
                lvd_sync_r[1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= RS_RUN;
      pin_len_r <= INT_PIN_TICKS;
    end else if (int_rst) begin
      state_r <= RS_PIN;
      pin_len_r <= lv_trip ? LV_PIN_TICKS : INT_PIN_TICKS;
    end else begin
      case (state_r)
        RS_RUN: begin
          if (stop_instr) begin
            state_r <= RS_STOP;
          end
        end
        RS_PIN: begin
          if (ref_tick && presc_r == pin_len_r - 13'h0001) begin
            state_r <= RS_HOLD;
          end
        end
        RS_HOLD: begin
          if (ref_tick &&
              presc_r == pin_len_r + CPU_HOLD_TICKS - 13'h0001) begin
            state_r <= RS_RUN;
          end
        end
        RS_STOP: begin
          if (wake) begin
            state_r <= RS_RECOV;
          end
        end
        RS_RECOV: begin
          if (ref_tick && presc_r == rec_len - 13'h0001) begin
            state_r <= RS_RUN;
          end
        end
        default: state_r <= RS_RUN;
      endcase
    end
  end

  // reset cause flags, cleared by software writing zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lv_cause_r <= 1'b0;
      usb_cause_r <= 1'b0;
    end else if (int_rst) begin
      lv_cause_r <= lv_trip;
      usb_cause_r <= ~lv_trip;
    end else if (apb_wr && paddr == OFS_STATUS) begin
      lv_cause_r <= lv_cause_r & pwdata[STAT_LV_CAUSE];
      usb_cause_r <= usb_cause_r & pwdata[STAT_USB_CAUSE];
    end
  end

  // ===========================================================
  // prescaler; the pin input is not looked at here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r <= PRESC_RESET;
    end else if (int_rst || state_r == RS_STOP) begin
      presc_r <= PRESC_RESET;
    end else if (ref_tick) begin
      presc_r <= presc_r + 13'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_tick <= 1'b0;
    end else begin
      watchdog_tick <= ref_tick && presc_r == 13'h1FFF &&
                       state_r != RS_STOP && !int_rst;
    end
  end

  // ===========================================================
  // pins and cpu control
  ris_state_t state_nxt;
  always_comb begin
    state_nxt = state_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_pin_o <= 1'b1;
      rst_pin_oe <= 1'b0;
      cpu_reset_n <= 1'b0;
      cpu_clk_en <= 1'b0;
    end else begin
      rst_pin_o <= 1'b0;
      rst_pin_oe <= state_nxt == RS_PIN;
      cpu_reset_n <= state_nxt != RS_PIN && state_nxt != RS_HOLD &&
                     pin_sync_r[1];
      cpu_clk_en <= state_nxt != RS_STOP && state_nxt != RS_RECOV;
    end
  end

  // ===========================================================
  // interrupt arbitration
  function automatic logic [4:0] pick_irq(input logic [15:1] req);
    logic [4:0] code;
    code = CODE_NONE;
    for (int i = NUM_IRQ; i >= 1; i--) begin
      if (req[i]) begin
        code = 5'(i); // lowest flag number wins
      end
    end
    return code;
  endfunction : pick_irq

  function automatic logic [15:0] code_vec(input logic [4:0] code);
    logic [15:0] v;
    v = VEC_FLAG1 - {10'h000, code - 5'h01, 1'b0};
    if (code == CODE_SWI) begin
      v = VEC_SWI;
    end
    if (code == CODE_RESET) begin
      v = VEC_RESET;
    end
    return v;
  endfunction : code_vec

  logic [4:0] hw_pick;
  logic in_reset;
  logic take_hw;
  logic take_swi;
  assign hw_pick = pick_irq(irq_req & irq_en);
  assign in_reset = state_r == RS_PIN || state_r == RS_HOLD;
  assign take_swi = instr_boundary & swi_instr;
  assign take_hw = instr_boundary & ~cpu_ibit &
                   hw_pick != CODE_NONE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_valid <= 1'b0;
      vec_code <= CODE_NONE;
      vec_addr <= VEC_RESET;
      stack_push <= 1'b0;
      push_pc_minus_one <= 1'b0;
      set_ibit <= 1'b0;
    end else if (in_reset || int_rst) begin
      vec_valid <= 1'b1;
      vec_code <= CODE_RESET;
      vec_addr <= VEC_RESET;
      stack_push <= 1'b0;
      push_pc_minus_one <= 1'b0;
      set_ibit <= 1'b0;
    end else if (vec_valid) begin
      stack_push <= 1'b0;
      set_ibit <= 1'b0;
      if (vec_ack) begin
        vec_valid <= 1'b0; // held until serviced
        vec_code <= CODE_NONE;
      end
    end else if (take_swi || take_hw) begin
      vec_valid <= 1'b1;
      vec_code <= take_swi ? CODE_SWI : hw_pick;
      vec_addr <= code_vec(take_swi ? CODE_SWI : hw_pick);
      stack_push <= 1'b1;
      set_ibit <= 1'b1;
      push_pc_minus_one <= ~take_swi;
    end else begin
      stack_push <= 1'b0;
      set_ibit <= 1'b0;
    end
  end

  // compatibility: the high index register is never stacked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      push_hreg <= 1'b0;
    end else begin
      push_hreg <= 1'b0;
    end
  end

  // ===========================================================
  // apb slave: zero wait states, answer registered at setup
  function automatic logic [31:0] read_mux(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h00000000;
    case (a)
      OFS_FLAGS_LOW: d = {24'h000000, irq_req[6:1], 2'b00};
      OFS_FLAGS_MID: d = {24'h000000, irq_req[14:7]};
      OFS_FLAGS_HIGH: d = {31'h00000000, irq_req[15]};
      OFS_CTRL: d = {28'h0000000, ctrl_r};
      OFS_STATUS: d = {3'h0, presc_r, 14'h0000,
                       usb_cause_r, lv_cause_r};
      default: d = 32'h00000000;
    endcase
    return d;
  endfunction : read_mux

  function automatic logic mapped(input logic [7:0] a);
    return a == OFS_FLAGS_LOW || a == OFS_FLAGS_MID ||
           a == OFS_FLAGS_HIGH || a == OFS_CTRL || a == OFS_STATUS;
  endfunction : mapped

  // flag registers have no write path at all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (apb_setup) begin
      pready <= 1'b1;
      pslverr <= ~mapped(paddr);
      prdata <= pwrite ? 32'h00000000 : read_mux(paddr);
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule : ris_top

/* rtl/ris_pkg.sv */
// ris_pkg: constants and types of the reset and interrupt sequencer
package ris_pkg;

  // ===========================================================
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int SE0_MIN_NS = 2500;
  // least time, rounded up to whole pclk cycles
  localparam int SE0_MIN_CYC = (SE0_MIN_NS + CLK_PERIOD_NS - 1) /
                               CLK_PERIOD_NS;
  localparam int SE0_CNT_W = 11;

  // ===========================================================
  // prescaler and sequence lengths, in reference-clock ticks
  localparam int PRESC_W = 13;
  localparam logic [12:0] PRESC_RESET = 13'h0000;
  localparam logic [12:0] LV_PIN_TICKS = 13'h1020;   // 4096 + 32
  localparam logic [12:0] INT_PIN_TICKS = 13'h0020;  // 32
  localparam logic [12:0] CPU_HOLD_TICKS = 13'h0020; // 32
  localparam logic [12:0] REC_LONG_TICKS = 13'h1000; // 4096
  localparam logic [12:0] REC_SHORT_TICKS = 13'h0020; // 32

  // ===========================================================
  // register map (byte addresses)
  localparam logic [7:0] OFS_FLAGS_LOW = 8'h00;
  localparam logic [7:0] OFS_FLAGS_MID = 8'h04;
  localparam logic [7:0] OFS_FLAGS_HIGH = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // control register fields
  localparam int CTRL_SHORT_REC = 0;
  localparam int CTRL_USB_EN = 1;
  localparam int CTRL_USB_RST_DIS = 2;
  localparam int CTRL_USB_TO_IRQ = 3;
  localparam logic [3:0] CTRL_RESET = 4'h2;

  // status register fields
  localparam int STAT_LV_CAUSE = 0;
  localparam int STAT_USB_CAUSE = 1;
  localparam int STAT_PRESC_LSB = 16;

  // ===========================================================
  // vectors and arbitration codes
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_SWI = 16'hFFFC;
  localparam logic [15:0] VEC_FLAG1 = 16'hFFFA;
  localparam logic [4:0] CODE_NONE = 5'h00;
  localparam logic [4:0] CODE_SWI = 5'h10;
  localparam logic [4:0] CODE_RESET = 5'h11;
  localparam int NUM_IRQ = 15;

  typedef enum logic [2:0] {
    RS_RUN,
    RS_PIN,
    RS_HOLD,
    RS_STOP,
    RS_RECOV
  } ris_state_t;

endpackage : ris_pkg

/* test/ris_chk.sv */
// ris_chk: port assertions for the reset and interrupt sequencer
`timescale 1ns/10ps
module ris_chk
  import ris_pkg::*;
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic rst_pin_o, // pin drive value
  input wire logic rst_pin_oe, // pin drive enable
  input wire logic cpu_reset_n, // cpu reset, active low
  input wire logic watchdog_tick, // wrap pulse
  input wire logic instr_boundary, // instruction end
  input wire logic swi_instr, // software interrupt
  input wire logic vec_ack, // vector fetched
  input wire logic vec_valid, // vector latched
  input wire logic [4:0] vec_code, // arbitration code
  input wire logic [15:0] vec_addr, // vector address
  input wire logic stack_push, // stacking pulse
  input wire logic push_pc_minus_one, // hardware entry
  input wire logic push_hreg, // high index stacking
  input wire logic set_ibit // mask set pulse
);
  // ========
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  pin_low_a: assert property (rst_pin_oe |-> !rst_pin_o)
    else $error("reset pin driven high");
  pin_holds_cpu_a: assert property (rst_pin_oe |-> !cpu_reset_n)
    else $error("cpu released while pin driven");
  reset_vec_a: assert property (rst_pin_oe |->
    vec_code == CODE_RESET && vec_addr == VEC_RESET)
    else $error("reset vector not selected");
  no_hreg_a: assert property (!push_hreg)
    else $error("high index register stacked");
  entry_pulse_a: assert property ($rose(vec_valid) && cpu_reset_n
    && vec_code != CODE_RESET |-> stack_push && set_ibit)
    else $error("entry without stacking and mask");
  push_once_a: assert property (stack_push |=> !stack_push)
    else $error("stacking pulse too long");
  latch_hold_a: assert property (vec_valid && !vec_ack && cpu_reset_n
    |=> $stable(vec_code))
    else $error("latched code displaced");
  hw_vec_a: assert property (vec_valid && vec_code inside {[1:15]}
    |-> vec_addr == 16'hFFFC - {10'h000, vec_code, 1'h0}
    && push_pc_minus_one)
    else $error("wrong hardware vector");
  swi_vec_a: assert property (vec_valid && vec_code == CODE_SWI
    |-> vec_addr == VEC_SWI && !push_pc_minus_one)
    else $error("wrong software vector");
  swi_take_a: assert property (instr_boundary && swi_instr
    && !vec_valid && cpu_reset_n && !rst_pin_oe
    |=> vec_valid && vec_code == CODE_SWI)
    else $error("software interrupt not taken");
  ack_free_a: assert property (vec_valid && vec_ack |=> !vec_valid)
    else $error("latch not freed by fetch");
  wd_pulse_a: assert property (watchdog_tick |=> !watchdog_tick)
    else $error("watchdog tick too long");

  cover property ($rose(vec_valid));
  cover property (watchdog_tick);
  cover property ($fell(rst_pin_oe));
endmodule : ris_chk

bind ris_top ris_chk u_chk (.pclk, .presetn, .rst_pin_o, .rst_pin_oe,
  .cpu_reset_n, .watchdog_tick, .instr_boundary, .swi_instr, .vec_ack,
  .vec_valid, .vec_code, .vec_addr, .stack_push, .push_pc_minus_one,
  .push_hreg, .set_ibit);

/* test/ris_cpu_model.sv */
// ris_cpu_model: cpu core that fetches the latched vector
`timescale 1ns/10ps
module ris_cpu_model (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic cpu_reset_n, // cpu held in reset, active low
  input wire logic vec_valid, // vector latched
  input wire logic [3:0] ack_dly, // cycles before fetch
  output logic vec_ack // vector fetched, pulse
);
  logic [3:0] wait_r;

  // a slow fetch keeps the latch busy so later requests must wait;
  // a cpu held in reset fetches nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_r <= 4'h0;
      vec_ack <= 1'h0;
    end else if (vec_ack) begin
      vec_ack <= 1'h0;
    end else if (vec_valid && cpu_reset_n && wait_r == ack_dly) begin
      vec_ack <= 1'h1;
      wait_r <= 4'h0;
    end else if (vec_valid && cpu_reset_n) begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule : ris_cpu_model

/* test/tb_top.sv */
// tb_top: bench for the reset and interrupt sequencer
`timescale 1ns/10ps
module tb_top
  import ris_pkg::*;
  ;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, osc_reference_clock = 1'h1, ext_low = 1'h0;
  logic low_voltage_detect = 1'h0, usb_dp = 1'h1, usb_dm = 1'h0;
  logic stop_instr = 1'h0, break_in = 1'h0, cpu_ibit = 1'h0;
  logic instr_boundary = 1'h0, swi_instr = 1'h0, perr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:1] irq_req = 15'h0, irq_en = 15'h7FFF;
  logic [3:0] ack_dly = 4'h2;
  logic pready, pslverr, rst_pin_o, rst_pin_oe, cpu_reset_n, cpu_clk_en;
  logic watchdog_tick, usb_addr_ready, usb_ext_irq, vec_ack, vec_valid;
  logic stack_push, push_pc_minus_one, push_hreg, set_ibit, rst_pin_i;
  logic [4:0] vec_code;
  logic [15:0] vec_addr;
  logic [2:0] ref_div = 3'h0;
  int fail_count = 0, checks_done = 0, cyc_n = 0, tk = 0, oe_cyc = 0;
  int xirq = 0, t0, t1, n, d;

  // reset pin has a pull-up; low when driven or pulled by the bench
  assign rst_pin_i = !(ext_low || (rst_pin_oe && !rst_pin_o));

  ris_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .osc_reference_clock, .low_voltage_detect,
    .usb_dp, .usb_dm, .rst_pin_i, .rst_pin_o, .rst_pin_oe, .cpu_reset_n,
    .cpu_clk_en, .watchdog_tick, .usb_addr_ready, .usb_ext_irq,
    .stop_instr, .break_in, .irq_req, .irq_en, .cpu_ibit, .instr_boundary,
    .swi_instr, .vec_ack, .vec_valid, .vec_code, .vec_addr, .stack_push,
    .push_pc_minus_one, .push_hreg, .set_ibit);
  ris_cpu_model cpu (.pclk, .presetn, .cpu_reset_n, .vec_valid, .ack_dly,
    .vec_ack);

  // ========
  always #2 pclk = ~pclk;

  // reference clock at pclk/6; tk counts its falling edges
  always @(posedge pclk) begin
    ref_div <= (ref_div == 3'h2) ? 3'h0 : ref_div + 3'h1;
    if (ref_div == 3'h2) osc_reference_clock <= ~osc_reference_clock;
    if (ref_div == 3'h2 && osc_reference_clock) tk <= tk + 1;
    if (rst_pin_oe) oe_cyc <= oe_cyc + 1;
    if (usb_ext_irq) xirq <= xirq + 1;
    cyc_n <= cyc_n + 1;
    if (cyc_n == 95000) begin
      fail_count = fail_count + 1;
      report_and_stop();
    end
  end

  // ========
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done = checks_done + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask : cyc

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] dat);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'h1;
    // only the bench timeout ends this wait
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic bnd(input logic s);
    @(posedge pclk);
    instr_boundary <= 1'h1;
    swi_instr <= s;
    @(posedge pclk);
    instr_boundary <= 1'h0;
    swi_instr <= 1'h0;
    cyc(2);
  endtask : bnd

  task automatic se0(input int c);
    @(posedge pclk);
    usb_dp <= 1'h0;
    cyc(c);
    usb_dp <= 1'h1;
  endtask : se0

  // ========
  initial begin
    cyc(5);
    presetn <= 1'h1;
    apb(1'h0, OFS_CTRL, 32'h0);
    chk(rd, {28'h0, CTRL_RESET});
    irq_req <= 15'h4B69;
    apb(1'h0, OFS_FLAGS_LOW, 32'h0);
    chk(rd, {24'h0, irq_req[6:1], 2'h0});
    apb(1'h0, OFS_FLAGS_MID, 32'h0);
    chk(rd, {24'h0, irq_req[14:7]});
    apb(1'h1, OFS_FLAGS_HIGH, 32'hFFFF_FFFF);
    apb(1'h0, OFS_FLAGS_HIGH, 32'h0);
    chk(rd, {31'h0, irq_req[15]});
    apb(1'h0, 8'h40, 32'h0);
    chk({31'h0, perr}, 32'h1);
    $display("test flags done");
    apb(1'h0, OFS_STATUS, 32'h0);
    t0 = tk;
    n = int'(rd[28:16]);
    ext_low <= 1'h1;
    cyc(60);
    ext_low <= 1'h0;
    cyc(10);
    apb(1'h0, OFS_STATUS, 32'h0);
    d = int'(rd[28:16]) - n - (tk - t0);
    chk({31'h0, d >= -2 && d <= 2}, 32'h1);
    $display("test prescaler done");
    for (int i = 1; i <= 15; i++) begin
      irq_req <= 15'h7FFF << (i - 1);
      bnd(1'h0);
      chk({27'h0, vec_code}, i);
      chk({16'h0, vec_addr}, 32'hFFFC - 2 * i);
      cyc(6);
    end
    for (int j = 0; j < 2; j++) begin
      cpu_ibit <= (j == 0);
      irq_en <= (j == 0) ? 15'h7FFF : 15'h0000;
      bnd(1'h0);
      chk({31'h0, vec_valid}, 32'h0);
    end
    cpu_ibit <= 1'h1;
    irq_en <= 15'h7FFF;
    bnd(1'h1);
    chk({11'h0, vec_code, vec_addr}, {11'h0, CODE_SWI, VEC_SWI});
    chk({31'h0, push_pc_minus_one}, 32'h0);
    cyc(6);
    cpu_ibit <= 1'h0;
    ack_dly <= 4'hF;
    irq_req <= 15'h0010;
    bnd(1'h0);
    irq_req <= 15'h0011;
    bnd(1'h0);
    chk({27'h0, vec_code}, 32'h5);
    cyc(24);
    bnd(1'h0);
    chk({27'h0, vec_code}, 32'h1);
    cyc(24);
    irq_req <= 15'h0;
    $display("test interrupts done");
    t0 = oe_cyc;
    se0(600);
    cyc(20);
    chk(oe_cyc - t0, 32'h0);
    se0(700);
    chk({31'h0, usb_addr_ready}, 32'h0);
    cyc(6);
    chk({31'h0, usb_addr_ready}, 32'h1);
    chk({31'h0, oe_cyc > t0}, 32'h1);
    for (n = 0; n < 2000 && cpu_reset_n !== 1'h1; n++) @(posedge pclk);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk({31'h0, rd[STAT_USB_CAUSE]}, 32'h1);
    for (int j = 0; j < 2; j++) begin
      apb(1'h1, OFS_CTRL, j ? 32'h8 : 32'hE);
      t0 = oe_cyc;
      t1 = xirq;
      se0(700);
      cyc(10);
      chk(xirq - t1, j ? 0 : 1);
      chk(oe_cyc - t0, 32'h0);
    end
    apb(1'h1, OFS_CTRL, 32'h2);
    $display("test usb done");
    low_voltage_detect <= 1'h1;
    for (n = 0; n < 20 && rst_pin_oe !== 1'h1; n++) @(posedge pclk);
    t0 = tk;
    low_voltage_detect <= 1'h0;
    chk({11'h0, vec_code, vec_addr}, {11'h0, CODE_RESET, VEC_RESET});
    for (n = 0; n < 30000 && rst_pin_oe !== 1'h0; n++) @(posedge pclk);
    t1 = tk;
    for (n = 0; n < 400 && cpu_reset_n !== 1'h1; n++) @(posedge pclk);
    chk({31'h0, t1 - t0 >= 4126 && t1 - t0 <= 4130}, 32'h1);
    chk({31'h0, tk - t1 >= 30 && tk - t1 <= 34}, 32'h1);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk({31'h0, rd[STAT_LV_CAUSE]}, 32'h1);
    $display("test low voltage done");
    for (n = 0; n < 30000 && watchdog_tick !== 1'h1; n++) @(posedge pclk);
    chk({31'h0, watchdog_tick}, 32'h1);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk({31'h0, rd[28:16] < 13'h0008}, 32'h1);
    $display("test watchdog done");
    for (int j = 0; j < 2; j++) begin
      apb(1'h1, OFS_CTRL, j ? 32'h2 : 32'h3);
      stop_instr <= 1'h1;
      @(posedge pclk);
      stop_instr <= 1'h0;
      cyc(8);
      chk({31'h0, cpu_clk_en}, 32'h0);
      apb(1'h0, OFS_STATUS, 32'h0);
      chk({19'h0, rd[28:16]}, 32'h0);
      break_in <= 1'h1;
      t0 = tk;
      for (n = 0; n < 30000 && cpu_clk_en !== 1'h1; n++) @(posedge pclk);
      break_in <= 1'h0;
      d = tk - t0 - (j ? 4096 : 32);
      chk({31'h0, d >= -1 && d <= 2}, 32'h1);
    end
    $display("test stop done");
    report_and_stop();
  end
endmodule : tb_top
